/* File: shared/gdi_pkg.sv */
// ****************************************************
// Constants and types of the bus port
// ****************************************************
package gdi_pkg;
   // Timing
   localparam int CLK_NS     = 100;
   localparam int SETTLE_NS  = 2000;
   localparam int SETTLE_CYC = (SETTLE_NS + CLK_NS - 1) / CLK_NS;
   localparam int CNT_W      = 8;
   localparam logic [CNT_W-1:0] SETTLE_LD = CNT_W'(SETTLE_CYC - 1);
   localparam logic [CNT_W-1:0] CNT_ZERO  = 8'h00;
   localparam logic [CNT_W-1:0] CNT_ONE   = 8'h01;

   // Synchronised pin vector layout
   localparam int NPIN   = 15;
   localparam int P_DHI  = 7;
   localparam int P_DAV  = 8;
   localparam int P_NRFD = 9;
   localparam int P_NDAC = 10;
   localparam int P_ATN  = 11;
   localparam int P_IFC  = 12;
   localparam int P_REN  = 13;
   localparam int P_EOI  = 14;

   // Command byte fields
   localparam int GRP_HI    = 6;
   localparam int GRP_LO    = 5;
   localparam int ADR_HI    = 4;
   localparam int SEC_LO    = 4;
   localparam int SENSE_BIT = 3;
   localparam int PPL_HI    = 2;
   localparam int RQS_BIT   = 6;
   localparam logic [1:0] GRP_LAD = 2'h1;
   localparam logic [1:0] GRP_TAD = 2'h2;
   localparam logic [1:0] GRP_SEC = 2'h3;
   localparam logic [2:0] SEC_PPE = 3'h6;
   localparam logic [2:0] SEC_PPD = 3'h7;

   // Interface messages
   localparam logic [6:0] CMD_GTL = 7'h01;
   localparam logic [6:0] CMD_SDC = 7'h04;
   localparam logic [6:0] CMD_PPC = 7'h05;
   localparam logic [6:0] CMD_GET = 7'h08;
   localparam logic [6:0] CMD_LLO = 7'h11;
   localparam logic [6:0] CMD_DCL = 7'h14;
   localparam logic [6:0] CMD_PPU = 7'h15;
   localparam logic [6:0] CMD_SPE = 7'h18;
   localparam logic [6:0] CMD_SPD = 7'h19;
   localparam logic [6:0] CMD_UNL = 7'h3F;
   localparam logic [6:0] CMD_UNT = 7'h5F;

   localparam logic [7:0] BYTE_ZERO = 8'h00;
   localparam logic [7:0] BYTE_ONE  = 8'h01;

   typedef enum logic [2:0] {A_IDLE, A_NRDY, A_RDY, A_ACC, A_WAIT} gdi_ah_t;
   typedef enum logic [1:0] {S_IDLE, S_SETTLE, S_TRANS} gdi_sh_t;
endpackage

/* File: hw/gdi_top.sv */
// Operation
// - Bytes move eight data lines in parallel
// - D0 is LSB, D7 is MSB
// - IFC low resets interface functions
// - ATN low: interface messages; high: device data
// - Pull SRQ low to request service
// - Remote only while REN is low
// - EOI with ATN high marks last byte
// - EOI with ATN low: answer parallel poll
// - DAV low only with valid data
// - NRFD low holds off; no DAV then
// - NDAC low until byte accepted
// - Full source handshake
// - Full acceptor handshake
// - Listener; own talk address unlistens
// - Talker with serial poll; own listen untalks
// - Full service request
// - Full parallel poll, controller configured
// - Remote/local with local lockout
// - Universal and addressed device clear
// - Addressed trigger raises trigger pulse
`timescale 1ns/1ps
module gdi_top (
   // Clock and reset
   input  wire logic       clk_sys_i,
   input  wire logic       reset_n_i,
   // Bus pins, input side
   input  wire logic [7:0] dio_i,
   input  wire logic       dav_n_i,
   input  wire logic       nrfd_n_i,
   input  wire logic       ndac_n_i,
   input  wire logic       atn_n_i,
   input  wire logic       ifc_n_i,
   input  wire logic       ren_n_i,
   input  wire logic       eoi_n_i,
   // Bus pins, open-drain output side
   output logic [7:0]      dio_o,
   output logic [7:0]      dio_oe_o,
   output logic            dav_n_o,
   output logic            dav_oe_o,
   output logic            nrfd_n_o,
   output logic            nrfd_oe_o,
   output logic            ndac_n_o,
   output logic            ndac_oe_o,
   output logic            eoi_n_o,
   output logic            eoi_oe_o,
   output logic            srq_n_o,
   output logic            srq_oe_o,
   // Configuration and status
   input  wire logic [4:0] my_addr_i,
   input  wire logic       rsv_i,
   input  wire logic [7:0] stb_i,
   input  wire logic       ist_i,
   input  wire logic       local_req_i,
   // Transmit stream
   input  wire logic [7:0] tx_data_i,
   input  wire logic       tx_end_i,
   input  wire logic       tx_valid_i,
   output logic            tx_ready_o,
   // Receive stream
   input  wire logic       rx_ready_i,
   output logic [7:0]      rx_data_o,
   output logic            rx_end_o,
   output logic            rx_valid_o,
   // Device events and state
   output logic            trigger_o,
   output logic            clear_o,
   output logic            remote_o,
   output logic            lockout_o,
   output logic            talker_o,
   output logic            listener_o
);
   import gdi_pkg::*;

   default clocking cb @(posedge clk_sys_i);
   endclocking
   default disable iff (!reset_n_i);

   // ****************************************************
   // Pin synchroniser
   // ****************************************************
   logic [NPIN-1:0] raw;
   logic [NPIN-1:0] s1_r;
   logic [NPIN-1:0] s2_r;
   logic [NPIN-1:0] s3_r;
   logic [NPIN-1:0] flt_r;
   logic [NPIN-1:0] flt_nxt;

   assign raw = {eoi_n_i, ren_n_i, ifc_n_i, atn_n_i,
                 ndac_n_i, nrfd_n_i, dav_n_i, dio_i};

   // New level only when stages two and three agree
   always_comb begin
      flt_nxt = (s2_r & s3_r) | (flt_r & (s2_r | s3_r));
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         s1_r  <= '1;
         s2_r  <= '1;
         s3_r  <= '1;
         flt_r <= '1;
      end else begin
         s1_r  <= raw;
         s2_r  <= s1_r;
         s3_r  <= s2_r;
         flt_r <= flt_nxt;
      end
   end

   // Asserted-true views of the low-active lines
   logic [7:0] dio_b;
   logic       dav;
   logic       rfd;
   logic       dac;
   logic       atn;
   logic       ifc;
   logic       ren;
   logic       eoi;

   assign dio_b = ~flt_r[P_DHI:0];
   assign dav   = ~flt_r[P_DAV];
   assign rfd   = flt_r[P_NRFD];
   assign dac   = flt_r[P_NDAC];
   assign atn   = ~flt_r[P_ATN];
   assign ifc   = ~flt_r[P_IFC];
   assign ren   = ~flt_r[P_REN];
   assign eoi   = ~flt_r[P_EOI];

   function automatic logic addr_hit(input logic [6:0] c,
                                     input logic [1:0] g,
                                     input logic [4:0] a);
      return (c[GRP_HI:GRP_LO] == g) && (c[ADR_HI:0] == a);
   endfunction

   // ****************************************************
   // Acceptor handshake and interface functions
   // ****************************************************
   gdi_ah_t    ah_r;
   gdi_ah_t    ah_nxt;
   logic       lad_r,  lad_nxt;
   logic       tad_r,  tad_nxt;
   logic       spms_r, spms_nxt;
   logic       rem_r,  rem_nxt;
   logic       llo_r,  llo_nxt;
   logic       ppc_r,  ppc_nxt;
   logic       ppe_r,  ppe_nxt;
   logic       pps_r,  pps_nxt;
   logic [2:0] ppl_r,  ppl_nxt;
   logic [7:0] rxd_r,  rxd_nxt;
   logic       rxe_r,  rxe_nxt;
   logic       rxv_r,  rxv_nxt;
   logic       trg_r,  trg_nxt;
   logic       clr_r,  clr_nxt;
   logic       ah_act;
   logic       take;
   logic [6:0] c;

   assign ah_act = atn || lad_r;
   assign c      = dio_b[6:0];

   always_comb begin
      ah_nxt   = ah_r;
      lad_nxt  = lad_r;
      tad_nxt  = tad_r;
      spms_nxt = spms_r;
      rem_nxt  = rem_r;
      llo_nxt  = llo_r;
      ppc_nxt  = ppc_r;
      ppe_nxt  = ppe_r;
      pps_nxt  = pps_r;
      ppl_nxt  = ppl_r;
      rxd_nxt  = rxd_r;
      rxe_nxt  = rxe_r;
      rxv_nxt  = 1'b0;
      trg_nxt  = 1'b0;
      clr_nxt  = 1'b0;
      take     = 1'b0;
      unique case (ah_r)
         A_IDLE: begin
            if (ah_act)
               ah_nxt = A_NRDY;
         end
         A_NRDY: begin
            if (!ah_act)
               ah_nxt = A_IDLE;
            else if (atn || rx_ready_i)
               ah_nxt = A_RDY;
         end
         A_RDY: begin
            if (!ah_act)
               ah_nxt = A_IDLE;
            else if (!(atn || rx_ready_i))
               ah_nxt = A_NRDY;
            else if (dav) begin
               ah_nxt = A_ACC;
               take   = 1'b1;
            end
         end
         A_ACC: begin
            ah_nxt = A_WAIT;
         end
         A_WAIT: begin
            if (!dav)
               ah_nxt = A_NRDY;
         end
      endcase
      if (take && !atn) begin
         rxd_nxt = dio_b;
         rxe_nxt = eoi;
         rxv_nxt = 1'b1;
      end
      if (local_req_i && !llo_r)
         rem_nxt = 1'b0;
      if (take && atn) begin
         if (c[GRP_HI:GRP_LO] != GRP_SEC)
            ppc_nxt = 1'b0;
         if (c == CMD_UNL)
            lad_nxt = 1'b0;
         else if (addr_hit(c, GRP_LAD, my_addr_i)) begin
            lad_nxt = 1'b1;
            tad_nxt = 1'b0;
            if (ren)
               rem_nxt = 1'b1;
         end
         if (c == CMD_UNT)
            tad_nxt = 1'b0;
         else if (addr_hit(c, GRP_TAD, my_addr_i)) begin
            tad_nxt = 1'b1;
            lad_nxt = 1'b0;
         end else if (c[GRP_HI:GRP_LO] == GRP_TAD)
            tad_nxt = 1'b0;
         if (c[GRP_HI:GRP_LO] == GRP_SEC && ppc_r) begin
            if (c[GRP_HI:SEC_LO] == SEC_PPE) begin
               ppe_nxt = 1'b1;
               pps_nxt = c[SENSE_BIT];
               ppl_nxt = c[PPL_HI:0];
            end else if (c[GRP_HI:SEC_LO] == SEC_PPD)
               ppe_nxt = 1'b0;
         end
         unique case (c)
            CMD_GTL: if (lad_r) rem_nxt = 1'b0;
            CMD_LLO: llo_nxt = 1'b1;
            CMD_SDC: clr_nxt = lad_r;
            CMD_DCL: clr_nxt = 1'b1;
            CMD_GET: trg_nxt = lad_r;
            CMD_PPC: ppc_nxt = lad_r;
            CMD_PPU: ppe_nxt = 1'b0;
            CMD_SPE: spms_nxt = 1'b1;
            CMD_SPD: spms_nxt = 1'b0;
            default: ;
         endcase
      end
      if (!ren) begin
         rem_nxt = 1'b0;
         llo_nxt = 1'b0;
      end
      if (ifc) begin
         lad_nxt  = 1'b0;
         tad_nxt  = 1'b0;
         spms_nxt = 1'b0;
         ppc_nxt  = 1'b0;
      end
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         ah_r   <= A_IDLE;
         lad_r  <= 1'b0;
         tad_r  <= 1'b0;
         spms_r <= 1'b0;
         rem_r  <= 1'b0;
         llo_r  <= 1'b0;
         ppc_r  <= 1'b0;
         ppe_r  <= 1'b0;
         pps_r  <= 1'b0;
         ppl_r  <= 3'h0;
         rxd_r  <= BYTE_ZERO;
         rxe_r  <= 1'b0;
         rxv_r  <= 1'b0;
         trg_r  <= 1'b0;
         clr_r  <= 1'b0;
      end else begin
         ah_r   <= ah_nxt;
         lad_r  <= lad_nxt;
         tad_r  <= tad_nxt;
         spms_r <= spms_nxt;
         rem_r  <= rem_nxt;
         llo_r  <= llo_nxt;
         ppc_r  <= ppc_nxt;
         ppe_r  <= ppe_nxt;
         pps_r  <= pps_nxt;
         ppl_r  <= ppl_nxt;
         rxd_r  <= rxd_nxt;
         rxe_r  <= rxe_nxt;
         rxv_r  <= rxv_nxt;
         trg_r  <= trg_nxt;
         clr_r  <= clr_nxt;
      end
   end

   sequence s_accept;
      ah_r == A_RDY && ah_act && dav && (atn || rx_ready_i);
   endsequence

   a_accept_order: assert property (
      s_accept |=> (ah_r == A_ACC) ##1 (ah_r == A_WAIT) ##1 !ndac_oe_o)
      else $error("acceptor did not release NDAC after take");
   a_rx_eoi_mark: assert property (
      rxv_r |-> rxe_r == $past(eoi) && !$past(atn))
      else $error("received byte end flag or ATN wrong");
   a_ifc_clear: assert property (
      ifc |=> !lad_r && !tad_r && !spms_r)
      else $error("IFC did not clear addressing");
   a_addr_excl: assert property (
      !(lad_r && tad_r))
      else $error("talker and listener at once");
   a_remote_ren: assert property (
      $rose(rem_r) |-> $past(ren))
      else $error("remote entered without REN");
   a_nrfd_hold: assert property (
      ah_r == A_NRDY ##1 ah_r == A_NRDY |-> nrfd_oe_o)
      else $error("NRFD released while not ready");

   // ****************************************************
   // Source handshake
   // ****************************************************
   gdi_sh_t          sh_r;
   gdi_sh_t          sh_nxt;
   logic [CNT_W-1:0] cnt_r, cnt_nxt;
   logic [7:0]       txb_r, txb_nxt;
   logic             txe_r, txe_nxt;
   logic             txr_r, txr_nxt;
   logic             sps_r, sps_nxt;
   logic             srd_r, srd_nxt;
   logic             tact;
   logic [7:0]       sp_byte;

   assign tact = tad_r && !atn;

   always_comb begin
      sp_byte          = stb_i;
      sp_byte[RQS_BIT] = rsv_i;
      sh_nxt  = sh_r;
      cnt_nxt = cnt_r;
      txb_nxt = txb_r;
      txe_nxt = txe_r;
      txr_nxt = 1'b0;
      sps_nxt = sps_r && !atn;
      srd_nxt = srd_r && rsv_i;
      unique case (sh_r)
         S_IDLE: begin
            cnt_nxt = SETTLE_LD;
            if (tact && spms_r && !sps_r) begin
               txb_nxt = sp_byte;
               txe_nxt = 1'b0;
               sh_nxt  = S_SETTLE;
            end else if (tact && !spms_r && tx_valid_i && !txr_r) begin
               txb_nxt = tx_data_i;
               txe_nxt = tx_end_i;
               sh_nxt  = S_SETTLE;
            end
         end
         S_SETTLE: begin
            if (!tact)
               sh_nxt = S_IDLE;
            else if (cnt_r != CNT_ZERO)
               cnt_nxt = cnt_r - CNT_ONE;
            else if (rfd)
               sh_nxt = S_TRANS;
         end
         S_TRANS: begin
            if (!tact)
               sh_nxt = S_IDLE;
            else if (dac) begin
               sh_nxt = S_IDLE;
               if (spms_r) begin
                  sps_nxt = 1'b1;
                  srd_nxt = txb_r[RQS_BIT];
               end else
                  txr_nxt = 1'b1;
            end
         end
      endcase
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         sh_r  <= S_IDLE;
         cnt_r <= CNT_ZERO;
         txb_r <= BYTE_ZERO;
         txe_r <= 1'b0;
         txr_r <= 1'b0;
         sps_r <= 1'b0;
         srd_r <= 1'b0;
      end else begin
         sh_r  <= sh_nxt;
         cnt_r <= cnt_nxt;
         txb_r <= txb_nxt;
         txe_r <= txe_nxt;
         txr_r <= txr_nxt;
         sps_r <= sps_nxt;
         srd_r <= srd_nxt;
      end
   end

   sequence s_sent;
      sh_r == S_TRANS && tact && dac;
   endsequence

   a_send_release: assert property (
      s_sent |=> sh_r == S_IDLE ##1 !dav_oe_o)
      else $error("DAV not released after NDAC high");
   a_dav_ready: assert property (
      $rose(dav_oe_o) |-> $past(sh_r) == S_TRANS && $past(rfd, 2))
      else $error("DAV asserted without NRFD high");
   a_dav_data: assert property (
      dav_oe_o |-> dio_oe_o == txb_r && $stable(dio_oe_o))
      else $error("data not stable under DAV");

   // ****************************************************
   // Pin drivers
   // ****************************************************
   logic [7:0] dio_oe_r, dio_oe_nxt;
   logic       dav_oe_r, dav_oe_nxt;
   logic       nrfd_oe_r, nrfd_oe_nxt;
   logic       ndac_oe_r, ndac_oe_nxt;
   logic       eoi_oe_r, eoi_oe_nxt;
   logic       srq_oe_r, srq_oe_nxt;
   logic       lo_r;
   logic       pp_hit;

   assign pp_hit = atn && eoi && ppe_r && (ist_i == pps_r);

   always_comb begin
      if (sh_r != S_IDLE)
         dio_oe_nxt = txb_r;
      else if (pp_hit)
         dio_oe_nxt = BYTE_ONE << ppl_r;
      else
         dio_oe_nxt = BYTE_ZERO;
      dav_oe_nxt  = sh_r == S_TRANS;
      nrfd_oe_nxt = ah_r inside {A_NRDY, A_ACC, A_WAIT};
      ndac_oe_nxt = ah_r inside {A_NRDY, A_RDY, A_ACC};
      eoi_oe_nxt  = sh_r != S_IDLE && txe_r;
      srq_oe_nxt  = rsv_i && !srd_r;
   end

   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         dio_oe_r  <= BYTE_ZERO;
         dav_oe_r  <= 1'b0;
         nrfd_oe_r <= 1'b0;
         ndac_oe_r <= 1'b0;
         eoi_oe_r  <= 1'b0;
         srq_oe_r  <= 1'b0;
         lo_r      <= 1'b0;
      end else begin
         dio_oe_r  <= dio_oe_nxt;
         dav_oe_r  <= dav_oe_nxt;
         nrfd_oe_r <= nrfd_oe_nxt;
         ndac_oe_r <= ndac_oe_nxt;
         eoi_oe_r  <= eoi_oe_nxt;
         srq_oe_r  <= srq_oe_nxt;
         lo_r      <= 1'b0;
      end
   end

   a_ppoll_bit: assert property (
      pp_hit && sh_r == S_IDLE |=> dio_oe_o[$past(ppl_r)])
      else $error("parallel poll bit not driven");
   a_srq_cause: assert property (
      srq_oe_o |-> $past(rsv_i))
      else $error("SRQ pulled without service request");

   assign dio_o      = {8{lo_r}};
   assign dio_oe_o   = dio_oe_r;
   assign dav_n_o    = lo_r;
   assign dav_oe_o   = dav_oe_r;
   assign nrfd_n_o   = lo_r;
   assign nrfd_oe_o  = nrfd_oe_r;
   assign ndac_n_o   = lo_r;
   assign ndac_oe_o  = ndac_oe_r;
   assign eoi_n_o    = lo_r;
   assign eoi_oe_o   = eoi_oe_r;
   assign srq_n_o    = lo_r;
   assign srq_oe_o   = srq_oe_r;
   assign tx_ready_o = txr_r;
   assign rx_data_o  = rxd_r;
   assign rx_end_o   = rxe_r;
   assign rx_valid_o = rxv_r;
   assign trigger_o  = trg_r;
   assign clear_o    = clr_r;
   assign remote_o   = rem_r;
   assign lockout_o  = llo_r;
   assign talker_o   = tad_r;
   assign listener_o = lad_r;
endmodule

/* File: tb/gdi_ctrl_model.sv */
`timescale 1ns/1ps
// ********
// Controller and listener model of the bus
// ********
module gdi_ctrl_model (
   // Clock
   input  wire logic       clk_sys_i,
   // Resolved bus lines
   input  wire logic [7:0] dio_i,
   input  wire logic       dav_n_i,
   input  wire logic       nrfd_n_i,
   input  wire logic       ndac_n_i,
   input  wire logic       eoi_n_i,
   // Pull-down enables
   output logic [7:0]      dio_oe_o,
   output logic            dav_oe_o,
   output logic            nrfd_oe_o,
   output logic            ndac_oe_o,
   output logic            eoi_oe_o,
   // Waits that ran out
   output int              err_o
);
   initial begin
      dio_oe_o  = 8'h00;
      dav_oe_o  = 1'b0;
      nrfd_oe_o = 1'b0;
      ndac_oe_o = 1'b0;
      eoi_oe_o  = 1'b0;
      err_o     = 0;
   end

   function automatic logic pick(input int sel);
      case (sel)
         0:       pick = dav_n_i;
         1:       pick = nrfd_n_i;
         default: pick = ndac_n_i;
      endcase
   endfunction

   task automatic wait_for(input int sel, input logic lvl);
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (pick(sel) !== lvl && n < 3000);
      if (n >= 3000) err_o++;
   endtask

   // Both acceptor lines held low while listening
   task automatic listen(input logic on);
      nrfd_oe_o <= on;
      ndac_oe_o <= on;
      @(posedge clk_sys_i);
   endtask

   task automatic put_byte(input logic [7:0] b, input logic e,
                           input int slow);
      wait_for(1, 1'b1);
      dio_oe_o <= b;
      eoi_oe_o <= e;
      repeat (2 + slow) @(posedge clk_sys_i);
      dav_oe_o <= 1'b1;
      @(posedge clk_sys_i);
      wait_for(2, 1'b1);
      dav_oe_o <= 1'b0;
      dio_oe_o <= 8'h00;
      eoi_oe_o <= 1'b0;
      @(posedge clk_sys_i);
   endtask

   task automatic get_byte(output logic [7:0] b, output logic e,
                           input int slow);
      repeat (slow) @(posedge clk_sys_i);
      nrfd_oe_o <= 1'b0;
      wait_for(0, 1'b0);
      b = ~dio_i;
      e = ~eoi_n_i;
      nrfd_oe_o <= 1'b1;
      repeat (slow) @(posedge clk_sys_i);
      ndac_oe_o <= 1'b0;
      wait_for(0, 1'b1);
      ndac_oe_o <= 1'b1;
   endtask
endmodule

/* File: tb/gdi_top_tb.sv */
`timescale 1ns/1ps
// ********
// Bench of the bus port
// ********
module gdi_top_tb;
   import gdi_pkg::*;
   logic       clk_sys_i, reset_n_i;
   logic [7:0] dio_w, dio_oe, c_dio_oe, stb, tx_data, rx_data, b, v;
   logic       dav_w, nrfd_w, ndac_w, eoi_w, atn_oe, ifc_oe, ren_oe;
   logic       pp_eoi, dav_oe, nrfd_oe, ndac_oe, eoi_oe, srq_oe, rsv;
   logic       ist, local_req, tx_end, tx_valid, tx_ready, rx_ready;
   logic       rx_end, rx_valid, trigger, clear, remote, lockout;
   logic       talker, listener, c_dav, c_nrfd, c_ndac, c_eoi;
   logic       dav_prev, e, s;
   logic [2:0] ln;
   logic [4:0] addr, my_addr;
   logic [7:0] tx_b[6];
   logic [8:0] rxq[$], expq[$];
   int         fail_count, num_checks, cyc, trig_cnt, clr_cnt, err_m;
   int         t0, c0;

   assign dio_w  = ~(dio_oe | c_dio_oe);
   assign dav_w  = ~(dav_oe | c_dav);
   assign nrfd_w = ~(nrfd_oe | c_nrfd);
   assign ndac_w = ~(ndac_oe | c_ndac);
   assign eoi_w  = ~(eoi_oe | c_eoi | pp_eoi);

   gdi_top dut (.clk_sys_i(clk_sys_i), .reset_n_i(reset_n_i),
      .dio_i(dio_w), .dav_n_i(dav_w), .nrfd_n_i(nrfd_w), .ndac_n_i(ndac_w),
      .atn_n_i(~atn_oe), .ifc_n_i(~ifc_oe), .ren_n_i(~ren_oe),
      .eoi_n_i(eoi_w), .dio_o(), .dio_oe_o(dio_oe), .dav_n_o(),
      .dav_oe_o(dav_oe), .nrfd_n_o(), .nrfd_oe_o(nrfd_oe), .ndac_n_o(),
      .ndac_oe_o(ndac_oe), .eoi_n_o(), .eoi_oe_o(eoi_oe), .srq_n_o(),
      .srq_oe_o(srq_oe), .my_addr_i(my_addr), .rsv_i(rsv), .stb_i(stb),
      .ist_i(ist), .local_req_i(local_req), .tx_data_i(tx_data),
      .tx_end_i(tx_end), .tx_valid_i(tx_valid), .tx_ready_o(tx_ready),
      .rx_ready_i(rx_ready), .rx_data_o(rx_data), .rx_end_o(rx_end),
      .rx_valid_o(rx_valid), .trigger_o(trigger), .clear_o(clear),
      .remote_o(remote), .lockout_o(lockout), .talker_o(talker),
      .listener_o(listener));

   gdi_ctrl_model ctl (.clk_sys_i(clk_sys_i), .dio_i(dio_w),
      .dav_n_i(dav_w), .nrfd_n_i(nrfd_w), .ndac_n_i(ndac_w),
      .eoi_n_i(eoi_w), .dio_oe_o(c_dio_oe), .dav_oe_o(c_dav),
      .nrfd_oe_o(c_nrfd), .ndac_oe_o(c_ndac), .eoi_oe_o(c_eoi),
      .err_o(err_m));

   function automatic logic [7:0] lad(input logic [4:0] a);
      lad = {3'h1, a};
   endfunction
   function automatic logic [7:0] tad(input logic [4:0] a);
      tad = {3'h2, a};
   endfunction
   function automatic logic [7:0] f_stb(input logic [7:0] sb, input logic r);
      f_stb = {sb[7], r, sb[5:0]};
   endfunction
   function automatic logic [7:0] f_ppe(input logic sn, input logic [2:0] l);
      f_ppe = {1'b0, 3'h6, sn, l};
   endfunction
   function automatic logic [7:0] f_pp(input logic i, sn, input logic [2:0] l);
      f_pp = (i == sn) ? (8'h01 << l) : 8'h00;
   endfunction

   task automatic chk(input string nm, input logic [31:0] seen, exp);
      num_checks++;
      if (seen !== exp) begin
         fail_count++;
         $display("BAD %s exp %0h seen %0h", nm, exp, seen);
      end
   endtask

   task automatic wrap_up;
      if (fail_count == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask

   task automatic idle(input int n);
      repeat (n) @(posedge clk_sys_i);
   endtask

   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clk_sys_i);
         n++;
      end while (tx_ready !== 1'b1 && n < 3000);
      chk("tx_ready_seen", n < 3000, 1'b1);
   endtask

   // Command bytes under one ATN period
   task automatic cmds(input logic lst, input int n, input logic [7:0] b0,
                       input logic [7:0] b1 = 8'h00,
                       input logic [7:0] b2 = 8'h00);
      logic [7:0] q[3];
      q = '{b0, b1, b2};
      ctl.listen(1'b0);
      atn_oe <= 1'b1;
      idle(6);
      for (int i = 0; i < n; i++) ctl.put_byte(q[i], 1'b0, 0);
      ctl.listen(lst);
      atn_oe <= 1'b0;
      idle(8);
   endtask

   task automatic poll(output logic [7:0] pv);
      atn_oe <= 1'b1;
      pp_eoi <= 1'b1;
      idle(8);
      pv = ~dio_w;
      atn_oe <= 1'b0;
      pp_eoi <= 1'b0;
      idle(8);
   endtask

   initial begin
      clk_sys_i = 1'b0;
      forever #50 clk_sys_i = ~clk_sys_i;
   end

   always @(posedge clk_sys_i) begin
      if (rx_valid === 1'b1) rxq.push_back({rx_end, rx_data});
      if (trigger === 1'b1) trig_cnt++;
      if (clear === 1'b1) clr_cnt++;
      if (reset_n_i && dav_oe && !dav_prev) chk("nrfd_at_dav", nrfd_w, 1);
      dav_prev <= dav_oe;
      rx_ready <= ($urandom_range(0, 3) != 0);
      cyc++;
      if (cyc == 20000) begin
         fail_count++;
         wrap_up();
      end
   end

   initial begin
      void'($urandom(96));
      addr = 5'($urandom_range(0, 30));
      {reset_n_i, atn_oe, ifc_oe, ren_oe, pp_eoi, rsv, ist} = 7'h00;
      {local_req, tx_end, tx_valid} = 3'h0;
      {stb, tx_data} = 16'h0000;
      my_addr = addr;
      idle(10);
      reset_n_i <= 1'b1;
      idle(6);
      chk("talker", talker, 1'b0);
      chk("srq_oe", srq_oe, 1'b0);
      cmds(0, 1, lad(addr));
      chk("listener", listener, 1'b1);
      chk("remote", remote, 1'b0);
      ren_oe <= 1'b1;
      idle(8);
      cmds(0, 1, lad(addr));
      chk("remote", remote, 1'b1);
      rxq.delete();
      for (int i = 0; i < 8; i++) begin
         b = (i == 0) ? 8'h00 : (i == 1) ? 8'hFF : 8'($urandom);
         expq.push_back({i == 7, b});
         ctl.put_byte(b, i == 7, $urandom_range(0, 5));
      end
      idle(8);
      chk("rx_count", rxq.size(), 8);
      foreach (expq[i]) chk("rx_byte", rxq[i], expq[i]);
      cmds(0, 1, {1'b0, CMD_UNL});
      ctl.put_byte(8'h5A, 1'b0, 0);
      idle(8);
      chk("rx_refused", rxq.size(), 8);
      cmds(0, 2, lad(addr), {1'b0, CMD_LLO});
      chk("lockout", lockout, 1'b1);
      local_req <= 1'b1;
      idle(8);
      chk("remote_locked", remote, 1'b1);
      local_req <= 1'b0;
      cmds(0, 1, {1'b0, CMD_GTL});
      chk("remote_gtl", remote, 1'b0);
      ren_oe <= 1'b0;
      idle(8);
      chk("lockout_ren", lockout, 1'b0);
      ren_oe <= 1'b1;
      for (int i = 0; i < 2; i++) begin
         t0 = trig_cnt;
         c0 = clr_cnt;
         cmds(0, 3, {1'b0, CMD_GET}, {1'b0, CMD_SDC}, {1'b0, CMD_DCL});
         chk("trigger", trig_cnt - t0, i == 0 ? 1 : 0);
         chk("clear", clr_cnt - c0, i == 0 ? 2 : 1);
         cmds(0, 1, {1'b0, CMD_UNL});
      end
      cmds(0, 2, lad(addr), tad(addr));
      chk("talker", talker, 1'b1);
      chk("listener", listener, 1'b0);
      cmds(0, 1, lad(addr));
      chk("talker", talker, 1'b0);
      chk("listener", listener, 1'b1);
      for (int i = 0; i < 6; i++) tx_b[i] = 8'($urandom);
      cmds(1, 2, {1'b0, CMD_UNL}, tad(addr));
      fork
         begin
            for (int i = 0; i < 6; i++) begin
               tx_data <= tx_b[i];
               tx_end <= (i == 5);
               tx_valid <= 1'b1;
               wait_ready();
            end
            tx_valid <= 1'b0;
         end
         for (int j = 0; j < 6; j++) begin
            ctl.get_byte(b, e, $urandom_range(0, 6));
            chk("tx_byte", {e, b}, {j == 5, tx_b[j]});
         end
      join
      stb <= 8'($urandom);
      rsv <= 1'b1;
      idle(4);
      chk("srq_on", srq_oe, 1'b1);
      cmds(1, 1, {1'b0, CMD_SPE});
      ctl.get_byte(b, e, 2);
      chk("status", b, f_stb(stb, 1'b1));
      idle(6);
      chk("srq_off", srq_oe, 1'b0);
      cmds(0, 2, {1'b0, CMD_SPD}, {1'b0, CMD_UNT});
      chk("talker", talker, 1'b0);
      rsv <= 1'b0;
      s = 1'($urandom);
      ln = 3'($urandom);
      cmds(0, 3, lad(addr), {1'b0, CMD_PPC}, f_ppe(s, ln));
      for (int k = 0; k < 2; k++) begin
         ist <= k[0];
         idle(2);
         poll(v);
         chk("ppoll", v, f_pp(k[0], s, ln));
      end
      cmds(0, 1, {1'b0, CMD_PPU});
      poll(v);
      chk("ppoll_off", v, 8'h00);
      cmds(0, 1, tad(addr));
      ifc_oe <= 1'b1;
      idle(8);
      chk("ifc_talker", talker, 1'b0);
      ifc_oe <= 1'b0;
      idle(8);
      chk("handshake_waits", err_m, 0);
      wrap_up();
   end
endmodule
